// >>> verilog/ebs_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - bus request: release bus, acknowledge low
// - keep decoding external address during grant
// - external master never reaches internal registers
// - per chip select mode and state length
// - native mode passes bus; reset default
// - three-state read: address, select in first
// - three-state read strobe plus request second
// - three-state wait low before second ends
// - third state stable; capture data ending it
// - three-state write: strobe second, third stable
// - three-state length 1 to 15 clocks
// - four-state separate or multiplexed low address
// - four-state read first: latch strobe pulse
// - four-state read strobe plus request second
// - ready low before third inserts waits
// - four-state read capture at fourth start
// - four-state write first: address, data, strobe
// - four-state write strobe plus request second
// - fourth state drops write, buses held
// - four-state length 2 to 15 clocks
// - resume third edge after wait release
module ebs_sequencer (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire ebs_pkg::ebs_cfg_array_type cfg_in,
    input wire ebs_pkg::ebs_cpu_req_type cpu_req_in,
    input wire ebs_pkg::ebs_native_type native_in,
    input wire logic cpu_int_reg_sel_in,
    input wire logic int_mem_hit_in,
    input wire logic external_bus_request_n_in,
    input wire logic ext_wait_n_in,
    input wire logic [ebs_pkg::ADDR_W-1:0] ext_addr_in,
    input wire logic [ebs_pkg::DATA_W-1:0] ext_data_in,
    input wire logic ext_memory_request_n_in,
    input wire logic ext_io_request_n_in,
    output ebs_pkg::ebs_pins_type pins_out,
    output logic cpu_stall_out,
    output logic cpu_done_out,
    output logic [ebs_pkg::DATA_W-1:0] cpu_rdata_out,
    output logic int_reg_sel_out
);
    import ebs_pkg::*;

    typedef struct packed {
        ebs_state_type st;
        logic [3:0] cnt;
        logic [3:0] len;
        logic [1:0] cs_idx;
        logic is_io;
        logic is_write;
        logic four;
        logic mux;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic done;
    } ebs_seq_state_type;

    ebs_seq_state_type state_reg;
    ebs_seq_state_type state_next;

    // clamp a programmed length to the minimum of its mode
    function automatic logic [3:0] eff_len(input logic [1:0] mode, input logic [3:0] len);
        logic [3:0] min_len;
        min_len = (mode == MODE_FOUR_STATE) ? LEN_MIN_FOUR : LEN_MIN_THREE;
        return (len < min_len) ? min_len : len;
    endfunction

    logic external_bus_request_n_n_s;
    logic wait_n_s;
    logic ext_memory_request_n_n_s;
    logic ext_io_request_n_n_s;
    logic [ADDR_W-1:0] ext_addr_s;
    logic [DATA_W-1:0] ext_data_s;

    ebs_sync #(.WIDTH(4), .INIT(4'hF)) u_sync_ctrl (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .async_in({external_bus_request_n_in, ext_wait_n_in, ext_memory_request_n_in,
            ext_io_request_n_in}),
        .sync_out({external_bus_request_n_n_s, wait_n_s, ext_memory_request_n_n_s, ext_io_request_n_n_s})
    );

    ebs_sync #(.WIDTH(ADDR_W + DATA_W)) u_sync_bus (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .async_in({ext_addr_in, ext_data_in}),
        .sync_out({ext_addr_s, ext_data_s})
    );

    logic grant;
    logic [ADDR_W-1:0] dec_addr;
    logic dec_mem;
    logic dec_io;
    logic [NUM_CS-1:0] dec_sel;
    logic [1:0] dec_idx;
    logic dec_hit;

    assign grant = (state_reg.st == ST_GRANT);

    // during grant the decoder follows the external master's address
    always_comb
    begin
        if (grant)
        begin
            dec_addr = ext_addr_s;
            dec_mem = !ext_memory_request_n_n_s;
            dec_io = !ext_io_request_n_n_s;
        end
        else if (cpu_req_in.start)
        begin
            dec_addr = cpu_req_in.addr;
            dec_mem = !cpu_req_in.is_io;
            dec_io = cpu_req_in.is_io;
        end
        else
        begin
            dec_addr = native_in.addr;
            dec_mem = !native_in.memory_request_n;
            dec_io = !native_in.io_request_n;
        end
    end

    ebs_decode u_decode (
        .cfg_in(cfg_in),
        .addr_in(dec_addr),
        .mem_cycle_in(dec_mem),
        .io_cycle_in(dec_io),
        .int_mem_hit_in(int_mem_hit_in && !grant),
        .select_out(dec_sel),
        .index_out(dec_idx),
        .hit_out(dec_hit)
    );

    logic last;
    assign last = (state_reg.cnt == state_reg.len - 4'h1);

    always_comb
    begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.cnt = state_reg.cnt + 4'h1;
        case (state_reg.st)
            ST_IDLE:
            begin
                state_next.cnt = 4'h0;
                if (!external_bus_request_n_n_s && !cpu_req_in.start)
                begin
                    state_next.st = ST_GRANT;
                end
                else if (cpu_req_in.start && dec_hit
                    && cfg_in[dec_idx].mode != MODE_NATIVE)
                begin
                    state_next.st = ST_FIRST;
                    state_next.cs_idx = dec_idx;
                    state_next.four = (cfg_in[dec_idx].mode == MODE_FOUR_STATE);
                    state_next.mux = cfg_in[dec_idx].mux_addr;
                    state_next.len = eff_len(cfg_in[dec_idx].mode, cfg_in[dec_idx].state_len);
                    state_next.is_io = cpu_req_in.is_io;
                    state_next.is_write = cpu_req_in.is_write;
                    state_next.addr = cpu_req_in.addr;
                    state_next.wdata = cpu_req_in.wdata;
                end
                else if (cpu_req_in.start)
                begin
                    // native or unselected: the native bus carries it, finish at once
                    state_next.done = 1'b1;
                end
            end
            ST_FIRST:
            begin
                if (last)
                begin
                    state_next.st = ST_SECOND;
                    state_next.cnt = 4'h0;
                end
            end
            ST_SECOND:
            begin
                if (last)
                begin
                    state_next.cnt = 4'h0;
                    // synchronised wait already lags two clocks, so a low seen here was early
                    state_next.st = wait_n_s ? ST_THIRD : ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                state_next.cnt = 4'h0;
                if (wait_n_s)
                begin
                    state_next.st = ST_THIRD;
                end
            end
            ST_THIRD:
            begin
                if (last)
                begin
                    state_next.cnt = 4'h0;
                    if (!state_reg.is_write)
                    begin
                        state_next.rdata = ext_data_in;
                    end
                    if (state_reg.four)
                    begin
                        state_next.st = ST_FOURTH;
                    end
                    else
                    begin
                        state_next.st = ST_IDLE;
                        state_next.done = 1'b1;
                    end
                end
            end
            ST_FOURTH:
            begin
                if (last)
                begin
                    state_next.st = ST_IDLE;
                    state_next.cnt = 4'h0;
                    state_next.done = 1'b1;
                end
            end
            ST_GRANT:
            begin
                state_next.cnt = 4'h0;
                if (external_bus_request_n_n_s)
                begin
                    state_next.st = ST_IDLE;
                end
            end
            default:
            begin
                state_next.st = ST_IDLE;
                state_next.cnt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= '{st: ST_IDLE, cnt: 4'h0, len: LEN_RESET, cs_idx: 2'h0,
                is_io: 1'b0, is_write: 1'b0, four: 1'b0, mux: 1'b0,
                addr: '0, wdata: '0, rdata: '0, done: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    logic in_cycle;
    logic strobe_on;
    logic req_on;
    logic ale_on;
    ebs_state_type st;

    assign st = state_reg.st;
    assign in_cycle = (st == ST_FIRST) || (st == ST_SECOND) || (st == ST_WAIT)
        || (st == ST_THIRD) || (st == ST_FOURTH);
    // strobes stay put through the third state; four-state drops them in the fourth
    assign strobe_on = (st == ST_SECOND) || (st == ST_WAIT) || (st == ST_THIRD);
    assign req_on = strobe_on || (st == ST_FOURTH);
    // latch strobe high for the first half of the first state
    assign ale_on = state_reg.four && (st == ST_FIRST)
        && (state_reg.cnt < (state_reg.len >> 1));

    always_comb
    begin
        pins_out.bus_grant_ack_n = !grant;
        pins_out.chip_select_n = ~dec_sel;
        pins_out.addr_latch_strobe = 1'b0;
        if (grant)
        begin
            // address, data and strobes belong to the external master
            pins_out.addr = '0;
            pins_out.addr_oe_n = 1'b1;
            pins_out.data = '0;
            pins_out.data_oe_n = 1'b1;
            pins_out.ctrl_oe_n = 1'b1;
            pins_out.rd_n = 1'b1;
            pins_out.wr_n = 1'b1;
            pins_out.memory_request_n = 1'b1;
            pins_out.io_request_n = 1'b1;
        end
        else if (in_cycle)
        begin
            pins_out.addr = state_reg.addr;
            pins_out.addr_oe_n = 1'b0;
            pins_out.ctrl_oe_n = 1'b0;
            pins_out.chip_select_n = '1;
            pins_out.chip_select_n[state_reg.cs_idx] = 1'b0;
            pins_out.addr_latch_strobe = ale_on;
            pins_out.rd_n = !(strobe_on && !state_reg.is_write);
            pins_out.wr_n = !(strobe_on && state_reg.is_write);
            pins_out.memory_request_n = !(req_on && !state_reg.is_io);
            pins_out.io_request_n = !(req_on && state_reg.is_io);
            if (state_reg.four && state_reg.mux && st == ST_FIRST)
            begin
                pins_out.data = state_reg.addr[7:0];
                pins_out.data_oe_n = 1'b0;
            end
            else
            begin
                pins_out.data = state_reg.wdata;
                pins_out.data_oe_n = !state_reg.is_write;
            end
        end
        else
        begin
            // native format: the core's signals go to the pins untouched
            pins_out.addr = native_in.addr;
            pins_out.addr_oe_n = 1'b0;
            pins_out.data = native_in.wdata;
            pins_out.data_oe_n = !native_in.data_drive;
            pins_out.ctrl_oe_n = 1'b0;
            pins_out.rd_n = native_in.rd_n;
            pins_out.wr_n = native_in.wr_n;
            pins_out.memory_request_n = native_in.memory_request_n;
            pins_out.io_request_n = native_in.io_request_n;
        end
    end

    assign cpu_stall_out = (st != ST_IDLE) || (!external_bus_request_n_n_s && !cpu_req_in.start);
    assign cpu_done_out = state_reg.done;
    assign cpu_rdata_out = state_reg.rdata;
    // the external master has no path to the register file
    assign int_reg_sel_out = cpu_int_reg_sel_in && !grant;

    // external data is sampled only for the synchroniser chain's sake
    logic unused_ext_data;
    assign unused_ext_data = ^ext_data_s;
endmodule

// >>> verilog/ebs_pkg.sv
package ebs_pkg;

    localparam int NUM_CS = 4;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;

    // per chip select bus format
    localparam logic [1:0] MODE_NATIVE = 2'h0;
    localparam logic [1:0] MODE_THREE_STATE = 2'h1;
    localparam logic [1:0] MODE_FOUR_STATE = 2'h2;
    localparam logic [1:0] MODE_RESET = MODE_NATIVE;

    // state length in system clocks
    localparam logic [3:0] LEN_MIN_THREE = 4'h1;
    localparam logic [3:0] LEN_MIN_FOUR = 4'h2;
    localparam logic [3:0] LEN_RESET = 4'hF;

    // i/o high byte reserved for on-chip peripherals
    localparam logic [7:0] IO_PERIPH_PAGE = 8'h00;

    localparam int MEM_PAGE_LSB = 16;
    localparam int IO_PAGE_LSB = 8;

    typedef struct packed {
        logic enable;
        logic io_space;
        logic [7:0] lower_bound;
        logic [7:0] upper_bound;
        logic [1:0] mode;
        logic mux_addr;
        logic [3:0] state_len;
    } ebs_cs_cfg_type;

    typedef ebs_cs_cfg_type [NUM_CS-1:0] ebs_cfg_array_type;

    // cycle request from the cpu core
    typedef struct packed {
        logic start;
        logic is_io;
        logic is_write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ebs_cpu_req_type;

    // native bus signals from the cpu core, active low strobes
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic data_drive;
        logic rd_n;
        logic wr_n;
        logic memory_request_n;
        logic io_request_n;
    } ebs_native_type;

    // external pins; output enables are low while driving
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic addr_oe_n;
        logic [DATA_W-1:0] data;
        logic data_oe_n;
        logic ctrl_oe_n;
        logic rd_n;
        logic wr_n;
        logic memory_request_n;
        logic io_request_n;
        logic addr_latch_strobe;
        logic [NUM_CS-1:0] chip_select_n;
        logic bus_grant_ack_n;
    } ebs_pins_type;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_FIRST = 7'b000_0010,
        ST_SECOND = 7'b000_0100,
        ST_WAIT = 7'b000_1000,
        ST_THIRD = 7'b001_0000,
        ST_FOURTH = 7'b010_0000,
        ST_GRANT = 7'b100_0000
    } ebs_state_type;

endpackage

// >>> verilog/ebs_sync.sv
`timescale 1ns/1ps
module ebs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } ebs_sync_state_type;

    ebs_sync_state_type state_reg;
    ebs_sync_state_type state_next;

    // first stage feeds only the second stage
    always_comb
    begin
        state_next.first = async_in;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= {INIT, INIT};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;
endmodule

// >>> verilog/ebs_decode.sv
`timescale 1ns/1ps
module ebs_decode (
    input wire ebs_pkg::ebs_cfg_array_type cfg_in,
    input wire logic [ebs_pkg::ADDR_W-1:0] addr_in,
    input wire logic mem_cycle_in,
    input wire logic io_cycle_in,
    input wire logic int_mem_hit_in,
    output logic [ebs_pkg::NUM_CS-1:0] select_out,
    output logic [1:0] index_out,
    output logic hit_out
);
    import ebs_pkg::*;

    logic [7:0] mem_page;
    logic [7:0] io_page;
    logic [NUM_CS-1:0] match;

    assign mem_page = addr_in[MEM_PAGE_LSB +: 8];
    assign io_page = addr_in[IO_PAGE_LSB +: 8];

    always_comb
    begin
        match = '0;
        for (int i = 0; i < NUM_CS; i++)
        begin
            if (cfg_in[i].enable && !cfg_in[i].io_space && mem_cycle_in && !int_mem_hit_in)
            begin
                match[i] = (mem_page >= cfg_in[i].lower_bound)
                    && (mem_page <= cfg_in[i].upper_bound);
            end
            if (cfg_in[i].enable && cfg_in[i].io_space && io_cycle_in)
            begin
                match[i] = (io_page == cfg_in[i].lower_bound) && (io_page != IO_PERIPH_PAGE);
            end
        end
    end

    // lowest numbered match wins
    always_comb
    begin
        select_out = '0;
        index_out = 2'h0;
        hit_out = 1'b0;
        for (int i = NUM_CS - 1; i >= 0; i--)
        begin
            if (match[i])
            begin
                select_out = '0;
                select_out[i] = 1'b1;
                index_out = 2'(i);
                hit_out = 1'b1;
            end
        end
    end
endmodule

// >>> dv/ebs_sequencer_sva.sv
`timescale 1ns/1ps
module ebs_seq_chk (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire ebs_pkg::ebs_native_type native_in,
    input wire logic cpu_int_reg_sel_in,
    input wire logic ext_wait_n_in,
    input wire ebs_pkg::ebs_pins_type pins_out,
    input wire logic cpu_stall_out,
    input wire logic int_reg_sel_out
);
    import ebs_pkg::*;
    logic seq;
    // grant also stalls the core, so strobe checks exclude it
    assign seq = cpu_stall_out && pins_out.bus_grant_ack_n;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_grant_release: assert property (
        !pins_out.bus_grant_ack_n |->
        pins_out.addr_oe_n && pins_out.data_oe_n && pins_out.ctrl_oe_n)
        else $error("bus held during grant");
    a_grant_no_regs: assert property (
        cpu_int_reg_sel_in |-> int_reg_sel_out == pins_out.bus_grant_ack_n)
        else $error("internal select wrong around grant");
    a_native_pass: assert property (
        !cpu_stall_out && pins_out.bus_grant_ack_n |-> pins_out.addr == native_in.addr
        && pins_out.rd_n == native_in.rd_n && pins_out.wr_n == native_in.wr_n)
        else $error("idle pins differ from native bus");
    a_strobe_pair: assert property (
        seq && !(pins_out.rd_n && pins_out.wr_n) |-> pins_out.chip_select_n != 4'hF
        && pins_out.memory_request_n != pins_out.io_request_n)
        else $error("strobe without select or single request");
    a_strobe_len: assert property (
        seq && $fell(pins_out.rd_n) |=> !pins_out.rd_n)
        else $error("read strobe shorter than two cycles");
    a_third_stable: assert property (
        seq && !pins_out.rd_n && $past(!pins_out.rd_n) |->
        $stable(pins_out.addr) && $stable(pins_out.chip_select_n))
        else $error("bus moved under read strobe");
    a_wr_stable: assert property (
        seq && !pins_out.wr_n && $past(!pins_out.wr_n) |->
        $stable(pins_out.addr) && $stable(pins_out.data) && $stable(pins_out.chip_select_n))
        else $error("bus moved under write strobe");
    a_wr_hold: assert property (
        seq && $rose(pins_out.wr_n) |->
        !pins_out.data_oe_n && $stable(pins_out.data) && $stable(pins_out.addr))
        else $error("buses not held after write strobe");
    a_wait_hold: assert property (
        (seq && !(pins_out.rd_n && pins_out.wr_n) && !ext_wait_n_in) [*3] |=>
        !(pins_out.rd_n && pins_out.wr_n))
        else $error("strobe ended while wait held");
    a_latch_fall: assert property (
        $fell(pins_out.addr_latch_strobe) |->
        pins_out.rd_n && pins_out.wr_n && pins_out.chip_select_n != 4'hF)
        else $error("latch strobe fell outside first state");
endmodule
bind ebs_sequencer ebs_seq_chk chk_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .native_in(native_in),
    .cpu_int_reg_sel_in(cpu_int_reg_sel_in), .ext_wait_n_in(ext_wait_n_in),
    .pins_out(pins_out), .cpu_stall_out(cpu_stall_out), .int_reg_sel_out(int_reg_sel_out));

// >>> dv/ebs_mem_model.sv
`timescale 1ns/1ps
module ebs_mem_model (
    input wire logic clk_in,
    input wire ebs_pkg::ebs_pins_type pins_in,
    input wire logic [7:0] wait_len_in,
    output logic [7:0] data_out,
    output logic wait_n_out
);
    import ebs_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] wcnt;
    logic sel, sel_q;
    assign sel = pins_in.chip_select_n != 4'hF;
    // wait pin has a pull-up: high whenever the count is spent
    assign wait_n_out = wcnt == 8'h00;
    initial
    begin
        data_out = 8'h5A;
        wcnt = 8'h00;
        sel_q = 1'b0;
    end
    always @(posedge clk_in)
    begin
        sel_q <= sel;
        if (sel && !sel_q)
            wcnt <= wait_len_in;
        else if (wcnt != 8'h00)
            wcnt <= wcnt - 8'h01;
        if (sel && !pins_in.wr_n && !pins_in.data_oe_n)
            mem[pins_in.addr[7:0]] <= pins_in.data;
        // released data lines toggle so a stale value is never mistaken for data
        data_out <= (sel && !pins_in.rd_n) ? mem[pins_in.addr[7:0]] : ~data_out;
    end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ebs_pkg::*;
    typedef struct {
        logic [7:0] rd;
        int cyc;
        logic [3:0] cs;
        logic [1:0] rq;
        int ale;
        logic adk;
        logic [7:0] ad;
    } ebs_exp_type;
    logic clk_in, nrst_in, isel, hit, breq_n, emreq_n, eioreq_n, ewait_n, stall, done, iselo;
    logic [23:0] eaddr, a;
    logic [7:0] edata, rdata, wl, last, d, ad_s;
    logic [31:0] rnd;
    logic [3:0] cs_s;
    logic [1:0] rq_s;
    logic [3:0] l3s [4];
    logic [3:0] l4s [4];
    ebs_cfg_array_type cfg;
    ebs_cpu_req_type req;
    ebs_native_type nat;
    ebs_pins_type pins;
    ebs_exp_type expq[$];
    ebs_exp_type e, m;
    int error_cnt, checks, cyc, ale, n, j, k, w, le;
    logic four;
    ebs_sequencer dut_u (
        .clk_in(clk_in), .nrst_in(nrst_in), .cfg_in(cfg), .cpu_req_in(req), .native_in(nat),
        .cpu_int_reg_sel_in(isel), .int_mem_hit_in(hit), .external_bus_request_n_in(breq_n),
        .ext_wait_n_in(ewait_n), .ext_addr_in(eaddr), .ext_data_in(edata),
        .ext_memory_request_n_in(emreq_n), .ext_io_request_n_in(eioreq_n), .pins_out(pins),
        .cpu_stall_out(stall), .cpu_done_out(done), .cpu_rdata_out(rdata),
        .int_reg_sel_out(iselo));
    ebs_mem_model mdl_u (
        .clk_in(clk_in), .pins_in(pins), .wait_len_in(wl), .data_out(edata),
        .wait_n_out(ewait_n));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // e holds the expectation; noted before the start edge is taken
    task automatic op(input logic io, input logic wr);
        @(negedge clk_in);
        req = '{start: 1'b1, is_io: io, is_write: wr, addr: a, wdata: d};
        expq.push_back(e);
        @(negedge clk_in);
        req.start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 200)
        begin
            @(negedge clk_in);
            n++;
        end
        // a cycle that never finishes leaves its note unchecked, so count it here
        if (done !== 1'b1)
            error_cnt++;
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        finish_test();
    end
    always @(posedge clk_in)
    begin
        if (req.start && !stall)
        begin
            cyc = 0;
            ale = 0;
            cs_s = 4'hF;
            rq_s = 2'h3;
        end
        else
            cyc++;
        if (pins.addr_latch_strobe)
        begin
            ale++;
            ad_s = pins.data;
        end
        if (!(pins.rd_n && pins.wr_n))
        begin
            cs_s = pins.chip_select_n;
            rq_s = {pins.memory_request_n, pins.io_request_n};
        end
        if (done === 1'b1 && expq.size() > 0)
        begin
            m = expq.pop_front();
            chk("latency", cyc, m.cyc);
            chk("rdata", rdata, m.rd);
            chk("chip_select", cs_s, m.cs);
            chk("request", rq_s, m.rq);
            chk("latch_cycles", ale, m.ale);
            if (m.adk)
                chk("latch_data", ad_s, m.ad);
        end
    end
    initial
    begin
        l3s = '{4'h0, 4'h1, 4'h4, 4'hF};
        l4s = '{4'h1, 4'h2, 4'h4, 4'hF};
        error_cnt = 0;
        checks = 0;
        rnd = 32'h0000_35a2;
        last = 8'h00;
        req = '0;
        nat = {32'h0, 1'b0, 4'hF};
        {isel, hit, breq_n, emreq_n, eioreq_n, eaddr, wl, nrst_in} = {5'b00111, 24'h0, 8'h0, 1'b0};
        for (k = 0; k < 4; k++)
        begin
            cfg[k] = '0;
            cfg[k].enable = 1'b1;
            cfg[k].lower_bound = 8'(k << 6);
            cfg[k].upper_bound = 8'(k << 6) + 8'h3F;
            cfg[k].mode = (k == 1 || k == 2) ? MODE_FOUR_STATE : MODE_THREE_STATE;
        end
        cfg[2].mux_addr = 1'b1;
        cfg[3].io_space = 1'b1;
        cfg[3].lower_bound = 8'h12;
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (16)
        begin
            @(negedge clk_in);
            rnd = lfsr(rnd);
            nat = {rnd, rnd[4:0]};
            isel = rnd[7];
            #1;
            chk("native_rd", pins.rd_n, nat.rd_n);
            chk("native_addr", pins.addr, nat.addr);
            chk("int_sel", iselo, isel);
        end
        nat = {32'h0, 1'b0, 4'hF};
        for (j = 0; j < 4; j++)
        begin
            {cfg[0].state_len, cfg[3].state_len} = {l3s[j], l3s[j]};
            {cfg[1].state_len, cfg[2].state_len} = {l4s[j], l4s[j]};
            wl = (j == 2) ? 8'h08 : 8'h00;
            for (k = 0; k < 4; k++)
            begin
                four = k == 1 || k == 2;
                le = four ? (l4s[j] < 2 ? 2 : l4s[j]) : (l3s[j] < 1 ? 1 : l3s[j]);
                rnd = lfsr(rnd);
                a = (k == 3) ? {16'h0012, rnd[7:0]} : {8'h10 + 8'(k << 6), rnd[15:0]};
                d = rnd[23:16];
                for (w = 0; w < 2; w++)
                begin
                    e.cyc = (four ? 4 : 3) * le + (wl != 0 ? wl - 5 : 0) + 1;
                    e.cs = ~(4'h1 << k);
                    e.rq = (k == 3) ? 2'h2 : 2'h1;
                    e.ale = four ? le / 2 : 0;
                    e.adk = k == 2 || (k == 1 && w == 0);
                    e.ad = (k == 2) ? a[7:0] : d;
                    e.rd = (w == 0) ? last : d;
                    if (w == 1)
                        last = d;
                    op(k == 3, w == 0);
                end
            end
        end
        wl = 8'h00;
        e = '{rd: last, cyc: 1, cs: 4'hF, rq: 2'h3, ale: 0, adk: 1'b0, ad: 8'h00};
        hit = 1'b1;
        a = 24'h10_0040;
        op(1'b0, 1'b1);
        hit = 1'b0;
        a = 24'hC0_0040;
        op(1'b0, 1'b1);
        // a chip select left in native format must finish like an unselected access
        cfg[0].mode = MODE_NATIVE;
        a = 24'h10_0040;
        op(1'b0, 1'b1);
        @(negedge clk_in);
        {breq_n, isel, hit} = 3'b011;
        n = 0;
        while (pins.bus_grant_ack_n !== 1'b0 && n < 20)
        begin
            @(negedge clk_in);
            n++;
        end
        chk("grant_ack", pins.bus_grant_ack_n, 1'b0);
        {eaddr, emreq_n} = {24'h90_0000, 1'b0};
        repeat (5) @(negedge clk_in);
        chk("grant_mem_cs", pins.chip_select_n, 4'hB);
        chk("grant_int_sel", iselo, 1'b0);
        {eaddr, emreq_n, eioreq_n} = {24'h00_1200, 2'b10};
        repeat (5) @(negedge clk_in);
        chk("grant_io_cs", pins.chip_select_n, 4'h7);
        {breq_n, eioreq_n, hit} = 3'b110;
        repeat (6) @(negedge clk_in);
        chk("grant_end", pins.bus_grant_ack_n, 1'b1);
        chk("int_sel_back", iselo, 1'b1);
        finish_test();
    end
endmodule
